// ### rtl/nvsram_host_consts.vh
`ifndef NVSRAM_HOST_CONSTS_VH
`define NVSRAM_HOST_CONSTS_VH
`define CLK_PERIOD_NS 10
`define ADDR_W 20
`define DATA_W 16
`define CNT_W 24
// Timing in documented units
`define CYCLE_TIME_FAST_NS 25
`define CYCLE_TIME_SLOW_NS 45
`define POWERUP_RECALL_TIME_MS 30
`define STORE_DURATION_MS 8
`define SOFT_RECALL_DURATION_US 600
`define COMMAND_PROCESSING_TIME_US 500
`define SLEEP_EXIT_TIME_MS 30
`define SLEEP_ENTRY_TIME_MS 8
`define LAST_WRITE_TO_SLEEP_US 0
// Commands
`define CMD_STORE 2'h0
`define CMD_RECALL 2'h1
`define CMD_AUTO_EN 2'h2
`define CMD_AUTO_DIS 2'h3
`define CMD_STEPS 3'h6
`define CMD_LAST_STEP 3'h5
`endif

// ### rtl/nvsram_cycle_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "nvsram_host_consts.vh"
module nvsram_cycle_timer (
   input wire sys_clk_i,
   input wire sys_rst_i,
   input wire load_i,
   input wire [`CNT_W-1:0] count_i,
   output wire done_o
);
   reg [`CNT_W-1:0] remain;
   // ----------------------------------------
   // Down counter
   // ----------------------------------------
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         remain <= {`CNT_W{1'b0}};
      end else if (load_i) begin
         remain <= count_i;
      end else if (remain != {`CNT_W{1'b0}}) begin
         remain <= remain - 1'b1;
      end
   end
   assign done_o = (remain == {`CNT_W{1'b0}}) && !load_i;
endmodule // nvsram_cycle_timer
`default_nettype wire

// ### rtl/nvsram_host.v
`timescale 1ns/100ps
`default_nettype none
`include "nvsram_host_consts.vh"
module nvsram_host #(
   parameter SLOW_GRADE = 0,
   parameter WIDE_BUS = 1,
   parameter DUAL_SELECT = 1,
   parameter [`ADDR_W-1:0] CMD_ADDR_0 = 20'h00001,
   parameter [`ADDR_W-1:0] CMD_ADDR_1 = 20'h00002,
   parameter [`ADDR_W-1:0] CMD_ADDR_2 = 20'h00003,
   parameter [`ADDR_W-1:0] CMD_ADDR_3 = 20'h00004,
   parameter [`ADDR_W-1:0] CMD_ADDR_4 = 20'h00005,
   parameter [`ADDR_W-1:0] ADDR_STORE = 20'h00010,
   parameter [`ADDR_W-1:0] ADDR_RECALL = 20'h00011,
   parameter [`ADDR_W-1:0] ADDR_AUTO_EN = 20'h00012,
   parameter [`ADDR_W-1:0] ADDR_AUTO_DIS = 20'h00013,
   parameter integer POWERUP_CYCLES = `POWERUP_RECALL_TIME_MS * 1000000 / `CLK_PERIOD_NS,
   parameter integer STORE_CYCLES = `STORE_DURATION_MS * 1000000 / `CLK_PERIOD_NS,
   parameter integer RECALL_CYCLES = `SOFT_RECALL_DURATION_US * 1000 / `CLK_PERIOD_NS,
   parameter integer PROCESS_CYCLES = `COMMAND_PROCESSING_TIME_US * 1000 / `CLK_PERIOD_NS,
   parameter integer WAKE_CYCLES = `SLEEP_EXIT_TIME_MS * 1000000 / `CLK_PERIOD_NS,
   parameter integer SLEEP_CYCLES = `SLEEP_ENTRY_TIME_MS * 1000000 / `CLK_PERIOD_NS
) (
   input wire sys_clk_i,
   input wire sys_rst_i,
   // User side
   input wire req_valid_i,
   input wire req_write_i,
   input wire req_clock_reg_i,
   input wire [`ADDR_W-1:0] req_addr_i,
   input wire [`DATA_W-1:0] req_wdata_i,
   input wire [1:0] req_lanes_i,
   output wire req_ready_o,
   output reg rsp_valid_o,
   output reg [`DATA_W-1:0] rsp_rdata_o,
   input wire cmd_valid_i,
   input wire [1:0] cmd_code_i,
   output wire cmd_ready_o,
   input wire hw_store_i,
   input wire sleep_i,
   output reg asleep_o,
   // Device side
   output reg [`ADDR_W-1:0] addr_o,
   input wire [`DATA_W-1:0] data_i,
   output reg [`DATA_W-1:0] data_o,
   output reg data_oe_o,
   output reg select_one_n_o,
   output reg select_two_n_o,
   output reg write_enable_n_o,
   output reg output_enable_n_o,
   output reg low_byte_lane_n_o,
   output reg high_byte_lane_n_o,
   input wire hw_store_busy_n_i,
   output reg hw_store_busy_n_o,
   output reg hw_store_busy_n_oe_o,
   output reg sleep_request_n_o
);
   localparam integer CYC_NS = SLOW_GRADE ? `CYCLE_TIME_SLOW_NS : `CYCLE_TIME_FAST_NS;
   localparam integer ACC_CYCLES = (CYC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam integer RC_CYCLES = RECALL_CYCLES + PROCESS_CYCLES;
   localparam [`CNT_W-1:0] ACC_CNT = ACC_CYCLES[`CNT_W-1:0];
   localparam [`CNT_W-1:0] PU_CNT = POWERUP_CYCLES[`CNT_W-1:0];
   localparam [`CNT_W-1:0] ST_CNT = STORE_CYCLES[`CNT_W-1:0];
   localparam [`CNT_W-1:0] RC_CNT = RC_CYCLES[`CNT_W-1:0];
   localparam [`CNT_W-1:0] PR_CNT = PROCESS_CYCLES[`CNT_W-1:0];
   localparam [`CNT_W-1:0] WK_CNT = WAKE_CYCLES[`CNT_W-1:0];
   localparam [`CNT_W-1:0] SL_CNT = SLEEP_CYCLES[`CNT_W-1:0];
   localparam [3:0] S_POWERUP = 4'h0;
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_SETUP = 4'h2;
   localparam [3:0] S_ACCESS = 4'h3;
   localparam [3:0] S_END = 4'h4;
   localparam [3:0] S_WAIT = 4'h5;
   localparam [3:0] S_HWSTORE = 4'h6;
   localparam [3:0] S_SLEEP = 4'h7;
   localparam [3:0] S_WAKE = 4'h8;
   reg [3:0] state;
   reg [3:0] after_wait;
   reg is_cmd;
   reg is_write;
   reg is_clock;
   reg [2:0] step;
   reg [1:0] cmd;
   reg [1:0] lanes;
   reg timer_load;
   reg [`CNT_W-1:0] timer_count;
   wire timer_done;
   // ----------------------------------------
   // Command address lookup
   // ----------------------------------------
   function [`ADDR_W-1:0] cmd_addr;
      input [2:0] idx;
      input [1:0] code;
      begin
         case (idx)
            3'h0: cmd_addr = CMD_ADDR_0;
            3'h1: cmd_addr = CMD_ADDR_1;
            3'h2: cmd_addr = CMD_ADDR_2;
            3'h3: cmd_addr = CMD_ADDR_3;
            3'h4: cmd_addr = CMD_ADDR_4;
            default: begin
               if (code == `CMD_STORE) cmd_addr = ADDR_STORE;
               else if (code == `CMD_RECALL) cmd_addr = ADDR_RECALL;
               else if (code == `CMD_AUTO_EN) cmd_addr = ADDR_AUTO_EN;
               else cmd_addr = ADDR_AUTO_DIS;
            end
         endcase
      end
   endfunction
   nvsram_cycle_timer u_timer (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .load_i(timer_load),
      .count_i(timer_count),
      .done_o(timer_done)
   );
   // Strap-free selection: idle level is deselected
   wire sel_n_one_idle = 1'b1;
   assign req_ready_o = (state == S_IDLE) && !sleep_i && !hw_store_i;
   assign cmd_ready_o = req_ready_o && !req_valid_i;
   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always @(posedge sys_clk_i) begin
      timer_load <= 1'b0;
      timer_count <= timer_count;
      rsp_valid_o <= 1'b0;
      if (sys_rst_i) begin
         state <= S_POWERUP;
         after_wait <= S_IDLE;
         is_cmd <= 1'b0;
         is_write <= 1'b0;
         is_clock <= 1'b0;
         step <= 3'h0;
         cmd <= `CMD_STORE;
         lanes <= 2'h0;
         timer_load <= 1'b1;
         timer_count <= PU_CNT;
         rsp_rdata_o <= {`DATA_W{1'b0}};
         asleep_o <= 1'b0;
         addr_o <= {`ADDR_W{1'b0}};
         data_o <= {`DATA_W{1'b0}};
         data_oe_o <= 1'b0;
         select_one_n_o <= sel_n_one_idle;
         select_two_n_o <= 1'b0;
         write_enable_n_o <= 1'b1;
         output_enable_n_o <= 1'b1;
         low_byte_lane_n_o <= 1'b1;
         high_byte_lane_n_o <= 1'b1;
         hw_store_busy_n_o <= 1'b1;
         hw_store_busy_n_oe_o <= 1'b0;
         sleep_request_n_o <= 1'b1;
      end else begin
         case (state)
            S_POWERUP: begin
               // Accesses would be ignored while recall runs
               if (timer_done) state <= S_IDLE;
            end
            S_IDLE: begin
               hw_store_busy_n_oe_o <= 1'b1;
               hw_store_busy_n_o <= 1'b1;
               if (hw_store_i) begin
                  hw_store_busy_n_o <= 1'b0;
                  timer_load <= 1'b1;
                  timer_count <= ST_CNT;
                  state <= S_HWSTORE;
               end else if (sleep_i) begin
                  sleep_request_n_o <= 1'b0;
                  timer_load <= 1'b1;
                  timer_count <= SL_CNT;
                  state <= S_SLEEP;
               end else if (req_valid_i || cmd_valid_i) begin
                  is_cmd <= !req_valid_i;
                  is_write <= req_valid_i && req_write_i;
                  is_clock <= req_valid_i && req_write_i && req_clock_reg_i;
                  cmd <= cmd_code_i;
                  step <= 3'h0;
                  addr_o <= req_valid_i ? req_addr_i : cmd_addr(3'h0, cmd_code_i);
                  data_o <= req_wdata_i;
                  lanes <= req_lanes_i;
                  // Clock writes set low lane first, before select or write enable
                  low_byte_lane_n_o <= (req_valid_i && req_write_i && req_clock_reg_i)
                     ? 1'b0 : 1'b1;
                  state <= S_SETUP;
               end
            end
            S_SETUP: begin
               // Select edge times the cycle; lanes are driven in this same cycle, except the low lane of clock writes
               select_one_n_o <= 1'b0;
               select_two_n_o <= DUAL_SELECT ? 1'b1 : 1'b0;
               write_enable_n_o <= !is_write;
               output_enable_n_o <= is_write;
               data_oe_o <= is_write;
               if (WIDE_BUS && !is_cmd) begin
                  low_byte_lane_n_o <= is_clock ? 1'b0 : !lanes[0];
                  high_byte_lane_n_o <= !lanes[1];
               end else begin
                  low_byte_lane_n_o <= 1'b0;
                  high_byte_lane_n_o <= 1'b0;
               end
               timer_load <= 1'b1;
               timer_count <= ACC_CNT;
               state <= S_ACCESS;
            end
            S_ACCESS: begin
               if (timer_done) begin
                  if (!is_write) rsp_rdata_o <= data_i;
                  select_one_n_o <= 1'b1;
                  select_two_n_o <= 1'b0;
                  write_enable_n_o <= 1'b1;
                  output_enable_n_o <= 1'b1;
                  state <= S_END;
               end
            end
            S_END: begin
               data_oe_o <= 1'b0;
               low_byte_lane_n_o <= 1'b1;
               high_byte_lane_n_o <= 1'b1;
               if (is_cmd && step != `CMD_LAST_STEP) begin
                  step <= step + 3'h1;
                  addr_o <= cmd_addr(step + 3'h1, cmd);
                  state <= S_SETUP;
               end else if (is_cmd) begin
                  // Sixth read data is discarded
                  rsp_rdata_o <= {`DATA_W{1'b0}};
                  timer_load <= 1'b1;
                  timer_count <= (cmd == `CMD_STORE) ? ST_CNT + PR_CNT
                     : (cmd == `CMD_RECALL) ? RC_CNT : PR_CNT;
                  after_wait <= S_IDLE;
                  state <= S_WAIT;
               end else begin
                  rsp_valid_o <= 1'b1;
                  state <= S_IDLE;
               end
            end
            S_WAIT: begin
               if (timer_done) begin
                  rsp_valid_o <= is_cmd;
                  state <= after_wait;
               end
            end
            S_HWSTORE: begin
               // Hold request low, then release to the device
               hw_store_busy_n_oe_o <= 1'b0;
               if (timer_done || (hw_store_busy_n_i && !hw_store_busy_n_oe_o
                     && !timer_load)) begin
                  state <= S_IDLE;
               end
            end
            S_SLEEP: begin
               data_oe_o <= 1'b0;
               if (timer_done) asleep_o <= 1'b1;
               if (timer_done && !sleep_i) begin
                  sleep_request_n_o <= 1'b1;
                  asleep_o <= 1'b0;
                  timer_load <= 1'b1;
                  timer_count <= WK_CNT;
                  state <= S_WAKE;
               end
            end
            S_WAKE: begin
               if (timer_done) state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
   // are device behaviour; this host never drives data on reads
endmodule // nvsram_host
`default_nettype wire

// ### tb/nvsram_host_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "nvsram_host_consts.vh"
module nvsram_host_asserts #(
   parameter integer POWERUP_CYCLES = 20,
   parameter integer WAKE_CYCLES = 20
) (
   input wire sys_clk_i,
   input wire sys_rst_i,
   input wire req_valid_i,
   input wire req_write_i,
   input wire req_clock_reg_i,
   input wire req_ready_o,
   input wire data_oe_o,
   input wire select_one_n_o,
   input wire select_two_n_o,
   input wire write_enable_n_o,
   input wire output_enable_n_o,
   input wire low_byte_lane_n_o,
   input wire hw_store_busy_n_o,
   input wire hw_store_busy_n_oe_o,
   input wire sleep_request_n_o
);
   // ----------------
   // Bus cycle checks
   // ----------------
   reg clk_wr;
   integer up_cnt, wake_cnt;
   wire sel = !select_one_n_o && select_two_n_o;
   always @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         clk_wr <= 1'b0;
         up_cnt <= 0;
         wake_cnt <= WAKE_CYCLES;
      end else begin
         if (req_valid_i && req_ready_o) clk_wr <= req_write_i && req_clock_reg_i;
         if (up_cnt < POWERUP_CYCLES) up_cnt <= up_cnt + 1;
         if (!sleep_request_n_o) wake_cnt <= 0;
         else if (wake_cnt < WAKE_CYCLES) wake_cnt <= wake_cnt + 1;
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_open; $fell(select_one_n_o); endsequence
   sequence s_hold; !select_one_n_o [*3]; endsequence
   AST_READ_WE_HIGH: assert property (sel && !output_enable_n_o |-> write_enable_n_o && !data_oe_o)
      else $error("write enable low or data driven in a read");
   AST_BUSY_IDLE: assert property (!select_one_n_o |-> hw_store_busy_n_oe_o && hw_store_busy_n_o)
      else $error("busy line not held high during an access");
   AST_CLK_LANE_HELD: assert property (!write_enable_n_o && clk_wr |-> !low_byte_lane_n_o)
      else $error("lane released inside a clock write");
   AST_CLK_LANE_FIRST: assert property ($fell(write_enable_n_o) && clk_wr |-> $past(low_byte_lane_n_o) == 1'b0)
      else $error("low lane late for a clock write");
   AST_DUAL_SELECT: assert property (!select_one_n_o |-> select_two_n_o)
      else $error("select two low while select one low");
   AST_CYCLE_LEN: assert property (s_open |-> s_hold)
      else $error("select shorter than a cycle time");
   AST_WAKE_GAP: assert property (s_open |-> wake_cnt == WAKE_CYCLES)
      else $error("access too soon after wake");
   AST_POWERUP: assert property (up_cnt < POWERUP_CYCLES - 1 |-> !req_ready_o)
      else $error("ready before power-up recall time");
endmodule // nvsram_host_asserts
bind nvsram_host nvsram_host_asserts #(.POWERUP_CYCLES(POWERUP_CYCLES), .WAKE_CYCLES(WAKE_CYCLES))
   nvsram_host_asserts_inst (.sys_clk_i, .sys_rst_i, .req_valid_i, .req_write_i, .req_clock_reg_i,
   .req_ready_o, .data_oe_o, .select_one_n_o, .select_two_n_o, .write_enable_n_o,
   .output_enable_n_o, .low_byte_lane_n_o, .hw_store_busy_n_o, .hw_store_busy_n_oe_o,
   .sleep_request_n_o);
`default_nettype wire

// ### tb/nvsram_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "nvsram_host_consts.vh"
module nvsram_dev_model #(
   parameter [`ADDR_W-1:0] SEQ_BASE = 20'h00001,
   parameter [`ADDR_W-1:0] CODE_BASE = 20'h00010
) (
   input wire sys_clk_i,
   input wire [`ADDR_W-1:0] addr_i,
   input wire [`DATA_W-1:0] wdata_i,
   input wire sel_one_n_i,
   input wire sel_two_n_i,
   input wire we_n_i,
   input wire oe_n_i,
   input wire lo_n_i,
   input wire hi_n_i,
   input wire sleep_n_i,
   input wire busy_line_i,
   output wire [`DATA_W-1:0] rdata_o,
   output wire busy_low_o,
   output reg [1:0] last_cmd_o,
   output reg [7:0] n_store_o
);
   // -------------------
   // Memory and commands
   // -------------------
   reg [15:0] mem [0:15];
   reg [15:0] last = 16'h0000;
   reg wrote = 1'b0, rd_q = 1'b0;
   reg [2:0] step = 3'h0;
   integer lock = 0;
   wire sel = !sel_one_n_i && sel_two_n_i;
   wire rd = sel && we_n_i && !oe_n_i && sleep_n_i && lock == 0;
   wire [15:0] q = mem[addr_i[3:0]];
   assign rdata_o = {rd && !hi_n_i ? q[15:8] : ~last[15:8], rd && !lo_n_i ? q[7:0] : ~last[7:0]};
   assign busy_low_o = lock != 0;
   initial n_store_o = 8'h00;
   always @(posedge sys_clk_i) begin
      last <= rdata_o;
      rd_q <= rd;
      if (lock != 0) lock <= lock - 1;
      else if (!busy_line_i && wrote) begin
         lock <= 10;
         wrote <= 1'b0;
         n_store_o <= n_store_o + 8'h01;
         // Write in progress still lands at store start
         if (sel && !we_n_i && !lo_n_i) mem[addr_i[3:0]][7:0] <= wdata_i[7:0];
         if (sel && !we_n_i && !hi_n_i) mem[addr_i[3:0]][15:8] <= wdata_i[15:8];
      end else if (sel && !we_n_i) begin
         if (!lo_n_i) mem[addr_i[3:0]][7:0] <= wdata_i[7:0];
         if (!hi_n_i) mem[addr_i[3:0]][15:8] <= wdata_i[15:8];
         wrote <= 1'b1;
         step <= 3'h0;
      end else if (rd && !rd_q) begin
         step <= 3'h0;
         if (step == 3'h5 && addr_i[19:2] == CODE_BASE[19:2]) begin
            last_cmd_o <= addr_i[1:0];
            if (!addr_i[1]) lock <= 10;
         end else if (step < 3'h5 && addr_i == SEQ_BASE + step) step <= step + 3'h1;
      end
   end
endmodule // nvsram_dev_model
`default_nettype wire

// ### tb/nvsram_host_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "nvsram_host_consts.vh"
module nvsram_host_tb_top;
   logic sys_clk_i, sys_rst_i, req_valid_i, req_write_i, req_clock_reg_i, cmd_valid_i;
   logic hw_store_i, sleep_i;
   logic [19:0] req_addr_i;
   logic [15:0] req_wdata_i, q;
   logic [1:0] req_lanes_i, cmd_code_i;
   wire req_ready_o, rsp_valid_o, cmd_ready_o, asleep_o, data_oe_o, select_one_n_o, select_two_n_o;
   wire write_enable_n_o, output_enable_n_o, low_byte_lane_n_o, high_byte_lane_n_o;
   wire hw_store_busy_n_o, hw_store_busy_n_oe_o, sleep_request_n_o, dev_low;
   wire [15:0] rsp_rdata_o, data_o, data_i;
   wire [19:0] addr_o;
   wire [1:0] last_cmd;
   wire [7:0] n_store;
   wire hw_store_busy_n_i = !((hw_store_busy_n_oe_o && !hw_store_busy_n_o) || dev_low);
   integer n_errors = 0, cmp_count = 0, cyc = 0, i;
   nvsram_host #(.POWERUP_CYCLES(20), .STORE_CYCLES(20),
      .PROCESS_CYCLES(20), .WAKE_CYCLES(20), .SLEEP_CYCLES(20)) nvsram_host_inst (
      .sys_clk_i, .sys_rst_i, .req_valid_i, .req_write_i, .req_clock_reg_i, .req_addr_i,
      .req_wdata_i, .req_lanes_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .cmd_valid_i,
      .cmd_code_i, .cmd_ready_o, .hw_store_i, .sleep_i, .asleep_o, .addr_o, .data_i, .data_o,
      .data_oe_o, .select_one_n_o, .select_two_n_o, .write_enable_n_o, .output_enable_n_o,
      .low_byte_lane_n_o, .high_byte_lane_n_o, .hw_store_busy_n_i, .hw_store_busy_n_o,
      .hw_store_busy_n_oe_o, .sleep_request_n_o);
   nvsram_dev_model nvsram_dev_model_inst (.sys_clk_i, .addr_i(addr_o),
      .wdata_i(data_oe_o ? data_o : ~data_o),
      .sel_one_n_i(select_one_n_o), .sel_two_n_i(select_two_n_o), .we_n_i(write_enable_n_o),
      .oe_n_i(output_enable_n_o), .lo_n_i(low_byte_lane_n_o), .hi_n_i(high_byte_lane_n_o),
      .sleep_n_i(sleep_request_n_o), .busy_line_i(hw_store_busy_n_i), .rdata_o(data_i),
      .busy_low_o(dev_low), .last_cmd_o(last_cmd), .n_store_o(n_store));
   // --------------
   // Shared helpers
   // --------------
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   task test_done;
      $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cyc = cyc + 1;
      if (cyc == 80000) begin
         n_errors = n_errors + 1;
         test_done;
      end
   end
   task chk(input [15:0] e, input [15:0] g);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         n_errors = n_errors + 1;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task wait_on(input integer what);
      integer k;
      k = 0;
      while (k < 65000 && (what == 0 ? rsp_valid_o : what == 1 ? req_ready_o
            : what == 2 ? asleep_o : cmd_ready_o) !== 1'b1) begin
         @(posedge sys_clk_i);
         #1 k = k + 1;
      end
      chk(16'h0001, {15'h0000, k < 65000});
   endtask
   task acc(input w, input c, input [19:0] a, input [15:0] d, input [1:0] l);
      {req_write_i, req_clock_reg_i, req_addr_i, req_wdata_i, req_lanes_i} = {w, c, a, d, l};
      req_valid_i = 1'b1;
      wait_on(1);
      @(posedge sys_clk_i);
      #1 req_valid_i = 1'b0;
      wait_on(0);
      q = rsp_rdata_o;
   endtask
   // ---------
   // Scenarios
   // ---------
   task t_lanes;
      acc(1'b1, 1'b0, 20'h00003, 16'hA55A, 2'h3);
      acc(1'b1, 1'b0, 20'h00003, 16'h1234, 2'h2);
      acc(1'b0, 1'b0, 20'h00003, 16'h0000, 2'h3);
      chk(16'h125A, q);
      acc(1'b1, 1'b1, 20'h00007, 16'h00C3, 2'h1);
      acc(1'b0, 1'b0, 20'h00007, 16'h0000, 2'h1);
      chk(16'h00C3, {8'h00, q[7:0]});
   endtask
   task t_cmds;
      for (i = 0; i < 4; i = i + 1) begin
         cmd_code_i = i[1:0];
         cmd_valid_i = 1'b1;
         wait_on(3);
         @(posedge sys_clk_i);
         #1 cmd_valid_i = 1'b0;
         wait_on(0);
         chk(i[15:0], {14'h0000, last_cmd});
         chk(16'h0000, rsp_rdata_o);
      end
   endtask
   task t_hw_store;
      acc(1'b1, 1'b0, 20'h00008, 16'h5AA5, 2'h3);
      for (i = 0; i < 2; i = i + 1) begin
         hw_store_i = 1'b1;
         @(posedge sys_clk_i);
         #1 hw_store_i = 1'b0;
         repeat (3) @(posedge sys_clk_i);
         #1 wait_on(1);
         chk(16'h0001, {8'h00, n_store});
      end
      acc(1'b0, 1'b0, 20'h00008, 16'h0000, 2'h3);
      chk(16'h5AA5, q);
   endtask
   task t_sleep;
      sleep_i = 1'b1;
      wait_on(2);
      chk(16'h0000, {15'h0000, sleep_request_n_o});
      sleep_i = 1'b0;
      acc(1'b0, 1'b0, 20'h00003, 16'h0000, 2'h3);
      chk(16'h125A, q);
   endtask
   initial begin
      {sys_rst_i, req_valid_i, req_write_i, req_clock_reg_i, cmd_valid_i, hw_store_i} = 6'h20;
      {sleep_i, req_addr_i, req_wdata_i, req_lanes_i, cmd_code_i} = 41'h0;
      repeat (2) @(posedge sys_clk_i);
      #1 sys_rst_i = 1'b0;
      t_lanes;
      t_cmds;
      t_hw_store;
      t_sleep;
      test_done;
   end
endmodule // nvsram_host_tb_top
`default_nettype wire
